// >>> rtl/dscirm_defines.svh
`ifndef DSCIRM_DEFINES_SVH
`define DSCIRM_DEFINES_SVH
// ************************************************************
// Register offsets.
// ************************************************************
`define DSCIRM_ADDR_IO 7'h04
`define DSCIRM_ADDR_CUR_M1 7'h30
`define DSCIRM_ADDR_CUR_M2 7'h50
`define DSCIRM_ADDR_POS_M1 7'h6A
`define DSCIRM_ADDR_POS_M2 7'h7A
`define DSCIRM_ADDR_PHASE_M1 7'h6B
`define DSCIRM_ADDR_PHASE_M2 7'h7B
`define DSCIRM_ADDR_CHOP_M1 7'h6C
`define DSCIRM_ADDR_CHOP_M2 7'h7C
`define DSCIRM_ADDR_SMART_M1 7'h6D
`define DSCIRM_ADDR_SMART_M2 7'h7D
`define DSCIRM_ADDR_DRV_M1 7'h6F
`define DSCIRM_ADDR_DRV_M2 7'h7F
// ************************************************************
// Field positions.
// ************************************************************
`define DSCIRM_HOLD_F 4:0
`define DSCIRM_RUN_F 12:8
`define DSCIRM_DELAY_F 19:16
`define DSCIRM_GPIO_LVL_F 2:0
`define DSCIRM_GPIO_DIR_F 10:8
`define DSCIRM_SMART_F 24:0
`define DSCIRM_PHASE_OFFSET 10'h100
// ************************************************************
// Reset values.
// ************************************************************
`define DSCIRM_RST_CUR 5'h00
`define DSCIRM_RST_DELAY 4'h0
`define DSCIRM_RST_CHOP 32'h00000000
`define DSCIRM_RST_SMART 25'h0000000
`define DSCIRM_RST_GPIO 3'h0
// ************************************************************
// Timing counts in clock cycles.
// ************************************************************
`define DSCIRM_PD_UNIT_CYC 262144
`define DSCIRM_STANDSTILL_CYC 65536
`define DSCIRM_CNT_W 24
`endif

// >>> rtl/dscirm_pkg.sv
package dscirm_pkg;
    // ************************************************************
    // Shared types.
    // ************************************************************
    typedef logic [6:0] dscirm_addr_t;

    // Power-down sequencer states of one motor.
    typedef enum logic [1:0] {
        pd_wait = 2'b00,
        pd_ramp = 2'b01,
        pd_hold = 2'b10
    } dscirm_pd_state_t;

    // Whole state of one motor channel.
    typedef struct packed {
        dscirm_pd_state_t st;
        logic [9:0] pos;
        logic [4:0] cur;
        logic [5:0] scale;
        logic [23:0] cnt;
        logic [8:0] phase_a;
        logic [8:0] phase_b;
    } dscirm_motor_t;

    // Whole state of the register bank.
    typedef struct packed {
        logic [2:0][3:0] gpio_sync;
        logic [2:0][1:0] step_sync;
        logic [2:0][1:0] dir_sync;
        logic [3:0] gpio_lvl;
        logic [1:0] step_lvl;
        logic [1:0] dir_lvl;
        logic [2:0] gpio_level;
        logic [2:0] gpio_dir;
        logic [1:0][4:0] hold;
        logic [1:0][4:0] run;
        logic [1:0][3:0] delay;
        logic [1:0][31:0] chop;
        logic [1:0][24:0] smart;
        logic [31:0] rdata;
        logic rvalid;
    } dscirm_regs_t;
endpackage

// >>> rtl/dscirm_motor_if.sv
`timescale 1ns/1ps
// Carries settings to one motor channel and its state back.
interface dscirm_motor_if;
    logic step;
    logic dir;
    logic [4:0] hold;
    logic [4:0] run;
    logic [3:0] delay;
    logic [9:0] pos;
    logic [8:0] phase_a;
    logic [8:0] phase_b;
    logic [5:0] scale;

    modport bank (output step, dir, hold, run, delay,
                  input pos, phase_a, phase_b, scale);
    modport motor (input step, dir, hold, run, delay,
                   output pos, phase_a, phase_b, scale);
endinterface

// >>> rtl/dscirm_motor.sv
`timescale 1ns/1ps
`include "dscirm_defines.svh"
module dscirm_motor #(
    parameter int PD_UNIT = `DSCIRM_PD_UNIT_CYC,
    parameter int STANDSTILL = `DSCIRM_STANDSTILL_CYC
) (
    // Clock, reset and freeze.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Link to the register bank.
    dscirm_motor_if.motor mif
);
    import dscirm_pkg::*;

    dscirm_motor_t r_ff;
    dscirm_motor_t nxt_r;
    logic [`DSCIRM_CNT_W-1:0] pd_limit;

    // ************************************************************
    // Wave table: a folded ramp, zero at position 0, so phase A
    // starts at zero current and phase B at the peak.
    // ************************************************************
    function automatic logic [8:0] table_value(input logic [9:0] p);
        logic [7:0] q;
        logic [8:0] mag;
        q = p[8] ? ~p[7:0] : p[7:0];
        mag = {1'b0, q};
        table_value = p[9] ? 9'(-mag) : mag;
    endfunction

    // Step, standstill wait, gradual power-down, then hold.
    always_comb begin
        pd_limit = `DSCIRM_CNT_W'(mif.delay) * `DSCIRM_CNT_W'(PD_UNIT);
        nxt_r = r_ff;
        if (mif.step) begin
            nxt_r.pos = mif.dir ? r_ff.pos - 10'h001 : r_ff.pos + 10'h001;
            nxt_r.cur = mif.run;
            nxt_r.st = pd_wait;
            nxt_r.cnt = '0;
        end else begin
            case (r_ff.st)
                pd_wait: begin
                    nxt_r.cur = mif.run;
                    if (r_ff.cnt >= `DSCIRM_CNT_W'(STANDSTILL - 1)) begin
                        nxt_r.cnt = '0;
                        if (mif.delay == 4'h0) begin
                            nxt_r.cur = mif.hold;
                            nxt_r.st = pd_hold;
                        end else begin
                            nxt_r.st = pd_ramp;
                        end
                    end else begin
                        nxt_r.cnt = r_ff.cnt + 1'b1;
                    end
                end
                pd_ramp: begin
                    if (r_ff.cur <= mif.hold || mif.delay == 4'h0) begin
                        nxt_r.cur = mif.hold;
                        nxt_r.st = pd_hold;
                    end else if (r_ff.cnt >= pd_limit - 1'b1) begin
                        nxt_r.cur = r_ff.cur - 5'h01;
                        nxt_r.cnt = '0;
                    end else begin
                        nxt_r.cnt = r_ff.cnt + 1'b1;
                    end
                end
                pd_hold: begin
                    nxt_r.cur = mif.hold;
                end
                default: begin
                    nxt_r.st = pd_hold;
                end
            endcase
        end
        nxt_r.scale = {1'b0, nxt_r.cur} + 6'h01;
        nxt_r.phase_a = table_value(nxt_r.pos);
        nxt_r.phase_b = table_value(nxt_r.pos + `DSCIRM_PHASE_OFFSET);
    end

    // All motor state in one register, frozen while ce is low.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '{st: pd_hold, pos: 10'h000, cur: `DSCIRM_RST_CUR,
                      scale: 6'h01, cnt: 24'h000000, phase_a: 9'h000,
                      phase_b: 9'h0FF};
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    assign mif.pos = r_ff.pos;
    assign mif.phase_a = r_ff.phase_a;
    assign mif.phase_b = r_ff.phase_b;
    assign mif.scale = r_ff.scale;
endmodule

// >>> rtl/dscirm_regs.sv
// Overview of operation
// - Output bits 0-2 drive gpio pins 0-2.
// - Direction bits 8-10 set gpio pins output.
// - Gpio pin 3 is always an input.
// - Version code readable in status bits 31:24.
// - Five-bit currents scale coil to (k+1)/32.
// - After standstill wait, ramp current down to hold.
// - Power-down delay zero switches to hold instantly.
// - Each ramp step lasts delay times 2^18 cycles.
// - Write-only current control at 0x30 and 0x50.
// - Read-only ten-bit table position per motor.
// - Phase B reads table at position plus 256.
// - Signed unscaled phase currents in bits 8:0, 24:16.
// - Read-write 32-bit chopper setup at 0x6C, 0x7C.
// - Write-only 25-bit smart current at 0x6D, 0x7D.
// - Read-only driver state at 0x6F, 0x7F.
`timescale 1ns/1ps
`include "dscirm_defines.svh"
module dscirm_regs #(
    // Arbitrary identification value, not tied to any part.
    parameter logic [7:0] VERSION = 8'h5A,
    parameter int PD_UNIT = `DSCIRM_PD_UNIT_CYC,
    parameter int STANDSTILL = `DSCIRM_STANDSTILL_CYC
) (
    // Clock, reset and freeze.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Register access port behind the serial interface.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dscirm_pkg::dscirm_addr_t reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Step and direction pins of both motors.
    input wire logic [1:0] step_pin,
    input wire logic [1:0] dir_pin,
    // Driver state from the power stages.
    input wire logic [31:0] drv_state_m1,
    input wire logic [31:0] drv_state_m2,
    // General IO pins.
    input wire logic [3:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe,
    // Settings and coil scaling handed to the power stages.
    output logic [1:0][31:0] chopper_setup,
    output logic [1:0][24:0] smart_current_setup,
    output logic [1:0][5:0] coil_scale
);
    import dscirm_pkg::*;

    // ************************************************************
    // Address tables, motor 1 in index 0.
    // ************************************************************
    localparam logic [1:0][6:0] CUR_ADDR =
        {`DSCIRM_ADDR_CUR_M2, `DSCIRM_ADDR_CUR_M1};
    localparam logic [1:0][6:0] POS_ADDR =
        {`DSCIRM_ADDR_POS_M2, `DSCIRM_ADDR_POS_M1};
    localparam logic [1:0][6:0] PHASE_ADDR =
        {`DSCIRM_ADDR_PHASE_M2, `DSCIRM_ADDR_PHASE_M1};
    localparam logic [1:0][6:0] CHOP_ADDR =
        {`DSCIRM_ADDR_CHOP_M2, `DSCIRM_ADDR_CHOP_M1};
    localparam logic [1:0][6:0] SMART_ADDR =
        {`DSCIRM_ADDR_SMART_M2, `DSCIRM_ADDR_SMART_M1};
    localparam logic [1:0][6:0] DRV_ADDR =
        {`DSCIRM_ADDR_DRV_M2, `DSCIRM_ADDR_DRV_M1};

    // ************************************************************
    // State and motor links.
    // ************************************************************
    dscirm_regs_t r_ff;
    dscirm_regs_t nxt_r;
    logic [1:0] step_pulse;
    logic [1:0][9:0] pos;
    logic [1:0][8:0] phase_a;
    logic [1:0][8:0] phase_b;
    logic [1:0][5:0] scale;
    logic [1:0][31:0] drv_state;

    assign drv_state = {drv_state_m2, drv_state_m1};

    // ************************************************************
    // Pin synchronisers.
    // ************************************************************

    // A pin level is taken only once the second and third stages
    // agree, so a single-cycle glitch never reaches the counters.
    always_comb begin
        nxt_r = r_ff;
        step_pulse = 2'b00;
        nxt_r.gpio_sync[0] = gpio_in;
        nxt_r.gpio_sync[1] = r_ff.gpio_sync[0];
        nxt_r.gpio_sync[2] = r_ff.gpio_sync[1];
        nxt_r.step_sync[0] = step_pin;
        nxt_r.step_sync[1] = r_ff.step_sync[0];
        nxt_r.step_sync[2] = r_ff.step_sync[1];
        nxt_r.dir_sync[0] = dir_pin;
        nxt_r.dir_sync[1] = r_ff.dir_sync[0];
        nxt_r.dir_sync[2] = r_ff.dir_sync[1];
        for (int b = 0; b < 4; b++) begin
            if (r_ff.gpio_sync[1][b] == r_ff.gpio_sync[2][b]) begin
                nxt_r.gpio_lvl[b] = r_ff.gpio_sync[2][b];
            end
        end
        for (int m = 0; m < 2; m++) begin
            if (r_ff.dir_sync[1][m] == r_ff.dir_sync[2][m]) begin
                nxt_r.dir_lvl[m] = r_ff.dir_sync[2][m];
            end
            if (r_ff.step_sync[1][m] == r_ff.step_sync[2][m]) begin
                nxt_r.step_lvl[m] = r_ff.step_sync[2][m];
                // A rising step level moves the table by one entry.
                step_pulse[m] = r_ff.step_sync[2][m] & ~r_ff.step_lvl[m];
            end
        end

        // ********************************************************
        // Register writes.
        // ********************************************************

        // Only writable offsets are decoded; a write to a read-only
        // or unmapped offset falls through and stores nothing.
        if (reg_wr) begin
            if (reg_addr == `DSCIRM_ADDR_IO) begin
                nxt_r.gpio_level = reg_wdata[`DSCIRM_GPIO_LVL_F];
                nxt_r.gpio_dir = reg_wdata[`DSCIRM_GPIO_DIR_F];
            end
            for (int m = 0; m < 2; m++) begin
                if (reg_addr == CUR_ADDR[m]) begin
                    nxt_r.hold[m] = reg_wdata[`DSCIRM_HOLD_F];
                    nxt_r.run[m] = reg_wdata[`DSCIRM_RUN_F];
                    nxt_r.delay[m] = reg_wdata[`DSCIRM_DELAY_F];
                end else if (reg_addr == CHOP_ADDR[m]) begin
                    nxt_r.chop[m] = reg_wdata;
                end else if (reg_addr == SMART_ADDR[m]) begin
                    nxt_r.smart[m] = reg_wdata[`DSCIRM_SMART_F];
                end
            end
        end

        // ********************************************************
        // Register reads.
        // ********************************************************

        // Reads answer one cycle later and never touch a setting.
        // Write-only and unmapped offsets read as zero.
        nxt_r.rvalid = reg_rd & ~reg_wr;
        nxt_r.rdata = 32'h00000000;
        if (reg_rd && !reg_wr) begin
            if (reg_addr == `DSCIRM_ADDR_IO) begin
                // Pin 3 has no direction bit and is read like the rest.
                nxt_r.rdata = {VERSION, 20'h00000, r_ff.gpio_lvl};
            end
            for (int m = 0; m < 2; m++) begin
                if (reg_addr == POS_ADDR[m]) begin
                    nxt_r.rdata = {22'h000000, pos[m]};
                end else if (reg_addr == PHASE_ADDR[m]) begin
                    nxt_r.rdata = {7'h00, phase_b[m],
                                   7'h00, phase_a[m]};
                end else if (reg_addr == CHOP_ADDR[m]) begin
                    nxt_r.rdata = r_ff.chop[m];
                end else if (reg_addr == DRV_ADDR[m]) begin
                    nxt_r.rdata = drv_state[m];
                end
            end
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************

    // All bank state in one register, frozen while ce is low. Pins
    // start as inputs so nothing is driven before software asks.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
            r_ff.gpio_level <= `DSCIRM_RST_GPIO;
            r_ff.gpio_dir <= `DSCIRM_RST_GPIO;
            r_ff.chop <= {`DSCIRM_RST_CHOP, `DSCIRM_RST_CHOP};
            r_ff.smart <= {`DSCIRM_RST_SMART, `DSCIRM_RST_SMART};
            r_ff.hold <= {`DSCIRM_RST_CUR, `DSCIRM_RST_CUR};
            r_ff.run <= {`DSCIRM_RST_CUR, `DSCIRM_RST_CUR};
            r_ff.delay <= {`DSCIRM_RST_DELAY, `DSCIRM_RST_DELAY};
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    // ************************************************************
    // Motor channels.
    // ************************************************************

    // Both channels are identical; only their settings differ.
    for (genvar g = 0; g < 2; g++) begin : g_motor
        dscirm_motor_if mif();

        assign mif.step = step_pulse[g];
        assign mif.dir = r_ff.dir_lvl[g];
        assign mif.hold = r_ff.hold[g];
        assign mif.run = r_ff.run[g];
        assign mif.delay = r_ff.delay[g];
        assign pos[g] = mif.pos;
        assign phase_a[g] = mif.phase_a;
        assign phase_b[g] = mif.phase_b;
        assign scale[g] = mif.scale;

        dscirm_motor #(
            .PD_UNIT(PD_UNIT),
            .STANDSTILL(STANDSTILL)
        ) u_motor (
            .clock(clock),
            .rst_n(rst_n),
            .ce(ce),
            .mif(mif)
        );
    end

    // ************************************************************
    // Outputs, each taken from a flip-flop.
    // ************************************************************

    // Pin 3 has no output driver at all, hence only three enables.
    assign gpio_out = r_ff.gpio_level;
    assign gpio_oe = r_ff.gpio_dir;
    assign reg_rdata = r_ff.rdata;
    assign reg_rvalid = r_ff.rvalid;
    assign chopper_setup = r_ff.chop;
    assign smart_current_setup = r_ff.smart;
    assign coil_scale = scale;
endmodule

// >>> sim/dscirm_host.sv
`timescale 1ns/1ps
// Host controller: register requests and step pulses, one at a time.
module dscirm_host (
    // Clock.
    input wire logic clock,
    // Register requests and answers.
    output logic reg_wr,
    output logic reg_rd,
    output dscirm_pkg::dscirm_addr_t reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // Step and direction pins.
    output logic [1:0] step_pin,
    output logic [1:0] dir_pin
);
    import dscirm_pkg::*;

    // Idle levels before the first request.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 32'h00000000;
        step_pin = 2'h0;
        dir_pin = 2'h0;
    end

    // One write, optionally with a clashing read in the same cycle.
    task automatic wr(input dscirm_addr_t a, input logic [31:0] d,
                      input logic r);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        // Released lines are inverted so a stale word never looks valid.
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read; the answer is taken once the strobe has settled.
    task automatic rd(input dscirm_addr_t a, output logic [31:0] q,
                      output logic v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clock);
        q = reg_rdata;
        v = reg_rvalid;
    endtask

    // One step with direction set up and pulse widths of three cycles.
    task automatic step(input int m, input logic d);
        @(posedge clock);
        dir_pin[m] <= d;
        repeat (3) @(posedge clock);
        step_pin[m] <= 1'b1;
        repeat (3) @(posedge clock);
        step_pin[m] <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
endmodule

// >>> sim/dscirm_regs_sva.sv
`timescale 1ns/1ps
`include "dscirm_defines.svh"
module dscirm_regs_sva #(
    parameter logic [7:0] VERSION = 8'h5A
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dscirm_pkg::dscirm_addr_t reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // Observed state and outputs.
    input wire logic [31:0] drv_state_m1,
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    input wire logic [1:0][31:0] chopper_setup,
    input wire logic [1:0][24:0] smart_current_setup,
    input wire logic [1:0][5:0] coil_scale
);
    import dscirm_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // A clashing read is dropped, so reads only count without a write.
    wire logic wr_ok = ce && reg_wr;
    wire logic rd_ok = ce && reg_rd && !reg_wr;
    wire logic w_io = wr_ok && reg_addr == `DSCIRM_ADDR_IO;

    gpio_level_a: assert property (
        w_io |=> gpio_out == $past(reg_wdata[2:0]))
        else $error("gpio level not taken from write");
    gpio_dir_a: assert property (
        w_io |=> gpio_oe == $past(reg_wdata[10:8]))
        else $error("gpio direction not taken from write");
    gpio_keep_a: assert property (
        !w_io |=> $stable(gpio_oe) && $stable(gpio_out))
        else $error("gpio setting changed without write");
    version_a: assert property (
        rd_ok && reg_addr == `DSCIRM_ADDR_IO |=> reg_rdata[31:24] == VERSION)
        else $error("version code wrong");
    chop_write_a: assert property (
        wr_ok && reg_addr == `DSCIRM_ADDR_CHOP_M1 |=>
        chopper_setup[0] == $past(reg_wdata))
        else $error("chopper setup not written");
    smart_write_a: assert property (
        wr_ok && reg_addr == `DSCIRM_ADDR_SMART_M2 |=>
        smart_current_setup[1] == $past(reg_wdata[24:0]))
        else $error("smart current setup not written");
    drv_read_a: assert property (
        rd_ok && reg_addr == `DSCIRM_ADDR_DRV_M1 |=>
        reg_rvalid && reg_rdata == $past(drv_state_m1))
        else $error("driver state read wrong");
    wo_read_a: assert property (
        rd_ok && reg_addr == `DSCIRM_ADDR_CUR_M2 |=>
        reg_rvalid && reg_rdata == 32'h00000000)
        else $error("write-only register read not zero");
    clash_a: assert property (
        ce && reg_wr && reg_rd |=> !reg_rvalid)
        else $error("clashing read answered");
    idle_data_a: assert property (
        !reg_rvalid |-> reg_rdata == 32'h00000000)
        else $error("read data without strobe");

    // Main scenarios reached.
    cover property (rd_ok ##1 reg_rvalid);
    cover property (wr_ok && reg_addr == `DSCIRM_ADDR_CUR_M1);
    cover property ($changed(coil_scale[0]));
endmodule

bind dscirm_regs dscirm_regs_sva #(.VERSION(VERSION)) dscirm_regs_sva_i (
    .clock(clock), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .drv_state_m1(drv_state_m1), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .chopper_setup(chopper_setup),
    .smart_current_setup(smart_current_setup), .coil_scale(coil_scale));

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    import dscirm_pkg::*;
    // Arbitrary identification value for this run.
    localparam logic [7:0] VER = 8'h3C;
    typedef struct {
        dscirm_addr_t a;
        logic [31:0] d;
        logic [31:0] q;
    } dscirm_row_t;
    dscirm_row_t rows [10];
    logic clock, rst_n, ce, reg_wr, reg_rd, reg_rvalid, v;
    dscirm_addr_t reg_addr;
    logic [31:0] reg_wdata, reg_rdata, q;
    logic [1:0] step_pin, dir_pin;
    logic [31:0] drv_m1, drv_m2;
    logic [3:0] gpio_in;
    logic [2:0] gpio_out, gpio_oe;
    logic [1:0][31:0] chop;
    logic [1:0][24:0] smart;
    logic [1:0][5:0] scale;
    int bad_count = 0;
    int comparisons = 0;
    int n;

    // Short counts keep the power-down ramp within a short run.
    dscirm_regs #(.VERSION(VER), .PD_UNIT(4), .STANDSTILL(8)) dscirm_regs_i (
        .clock(clock), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .step_pin(step_pin), .dir_pin(dir_pin), .drv_state_m1(drv_m1),
        .drv_state_m2(drv_m2), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .chopper_setup(chop),
        .smart_current_setup(smart), .coil_scale(scale));
    dscirm_host dscirm_host_i (
        .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .step_pin(step_pin), .dir_pin(dir_pin));

    // ************************************************************
    // Checking and verdict.
    // ************************************************************
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // The run needs about three hundred cycles; thirty times that means a hang.
    initial begin
        #100000;
        bad_count++;
        test_done();
    end

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        drv_m1 = 32'h80001234;
        drv_m2 = 32'h4000ABCD;
        gpio_in = 4'hA;
        rows[0] = '{7'h6C, 32'hA5A51234, 32'hA5A51234};
        rows[1] = '{7'h7C, 32'h0F0FF0F0, 32'h0F0FF0F0};
        rows[2] = '{7'h6D, 32'hFFFFFFFF, 32'h00000000};
        rows[3] = '{7'h7D, 32'h01234567, 32'h00000000};
        rows[4] = '{7'h50, 32'h000F1F05, 32'h00000000};
        rows[5] = '{7'h6F, 32'hFFFFFFFF, 32'h80001234};
        rows[6] = '{7'h7F, 32'h00000000, 32'h4000ABCD};
        rows[7] = '{7'h6A, 32'h000003FF, 32'h00000000};
        rows[8] = '{7'h6B, 32'hFFFFFFFF, 32'h00FF0000};
        rows[9] = '{7'h7E, 32'hFFFFFFFF, 32'h00000000};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            dscirm_host_i.wr(rows[i].a, rows[i].d, 1'b0);
            dscirm_host_i.rd(rows[i].a, q, v);
            chk("read word", rows[i].q, q);
            chk("read strobe", 32'h1, {31'h0, v});
        end
        chk("chopper m1", 32'hA5A51234, chop[0]);
        chk("chopper m2", 32'h0F0FF0F0, chop[1]);
        chk("smart m1", 32'h01FFFFFF, {7'h0, smart[0]});
        chk("smart m2", 32'h01234567, {7'h0, smart[1]});
        // Pins 0..2 levels and directions, pin 3 bits set to no effect.
        dscirm_host_i.wr(7'h04, 32'h00000D0B, 1'b0);
        dscirm_host_i.rd(7'h04, q, v);
        chk("gpio level", 32'h3, {29'h0, gpio_out});
        chk("gpio enable", 32'h5, {29'h0, gpio_oe});
        chk("input status", {VER, 24'h00000A}, q);
        // A write with a read in the same cycle: write only.
        dscirm_host_i.wr(7'h6C, 32'h13579BDF, 1'b1);
        @(negedge clock);
        chk("clash strobe", 32'h0, {31'h0, reg_rvalid});
        chk("clash write", 32'h13579BDF, chop[0]);
        // Frozen clock enable: a write in that cycle is not taken.
        @(posedge clock);
        ce <= 1'b0;
        dscirm_host_i.wr(7'h6C, 32'h2468ACE0, 1'b0);
        @(negedge clock);
        chk("frozen write", 32'h13579BDF, chop[0]);
        @(posedge clock);
        ce <= 1'b1;
        // Hold 3, run 20, no ramp.
        dscirm_host_i.wr(7'h30, 32'h00001403, 1'b0);
        dscirm_host_i.step(0, 1'b0);
        @(negedge clock);
        chk("run scale", 32'd21, {26'h0, scale[0]});
        dscirm_host_i.rd(7'h6A, q, v);
        chk("position up", 32'h1, q);
        repeat (20) @(negedge clock);
        chk("instant hold", 32'd4, {26'h0, scale[0]});
        dscirm_host_i.step(1, 1'b1);
        dscirm_host_i.rd(7'h7A, q, v);
        chk("position down", 32'h3FF, q);
        chk("run scale m2", 32'd32, {26'h0, scale[1]});
        // Step motor 2 back up, wrapping from 0x3FF to home position 0.
        dscirm_host_i.step(1, 1'b0);
        dscirm_host_i.rd(7'h7A, q, v);
        chk("position home", 32'h0, q);
        // Delay 2: each step of the ramp lasts 2 x 4 cycles.
        dscirm_host_i.wr(7'h30, 32'h00021403, 1'b0);
        dscirm_host_i.step(0, 1'b0);
        n = 0;
        while (scale[0] !== 6'd20 && n < 100) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (scale[0] === 6'd20 && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk("ramp step span", 32'd8, 32'(n));
        repeat (150) @(negedge clock);
        chk("ramp end", 32'd4, {26'h0, scale[0]});
        // Reset in mid-run.
        @(posedge clock);
        rst_n <= 1'b0;
        @(negedge clock);
        chk("reset scale", 32'h1, {26'h0, scale[0]});
        chk("reset enable", 32'h0, {29'h0, gpio_oe});
        test_done();
    end
endmodule
